// *** rtl/scg_access_check.sv ***
`timescale 1ns/1ns

module scg_access_check
    import scg_pkg::*;
#(
    parameter int NUM_UNITS = `SCG_NUM_UNITS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Access and current gates
    input wire scg_preq_s req,
    input wire logic [NUM_UNITS-1:0] clkEn,
    // Outcome, one cycle after the request
    output logic done,
    output logic fault,
    output scg_unit_t faultUnit
);

    localparam int SPAN = 1 << `SCG_UNIT_W;

    generate
        if (NUM_UNITS < 1 || NUM_UNITS > SPAN) begin : gBad
            $error("scg_access_check: NUM_UNITS out of range");
        end
    endgenerate

    // Units beyond the implemented ones count as unclocked
    wire logic [SPAN-1:0] enWide = {{(SPAN-NUM_UNITS){1'b0}}, clkEn};
    wire logic unitOn = enWide[req.unit];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done <= 1'b0;
            fault <= 1'b0;
            faultUnit <= '0;
        end else begin
            done <= req.valid && unitOn;
            fault <= req.valid && !unitOn;
            if (req.valid && !unitOn) begin
                faultUnit <= req.unit;
            end
        end
    end

endmodule

// *** rtl/scg_defs.svh ***
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH

// Register bus
`define SCG_ADDR_W 12
`define SCG_SLEEP_OFF 12'h114
`define SCG_STATUS_OFF 12'h118
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_SLVERR 2'h2

// Sleep enable register
`define SCG_SLEEP_RST 32'h0000_0000
`define SCG_RW_MASK 32'h0707_1013
`define SCG_BIT_ASP0 0
`define SCG_BIT_ASP1 1
`define SCG_BIT_SSP0 4
`define SCG_BIT_TWI0 12
`define SCG_BIT_TMR0 16
`define SCG_BIT_TMR1 17
`define SCG_BIT_TMR2 18
`define SCG_BIT_CMP0 24
`define SCG_BIT_CMP1 25
`define SCG_BIT_CMP2 26

// Status register fields
`define SCG_ST_MODE_LSB 16
`define SCG_ST_AUTO 18
`define SCG_ST_FAULT 20
`define SCG_ST_UNIT_LSB 24

// Gated units
`define SCG_NUM_UNITS 10
`define SCG_UNIT_W 4

`endif

// *** rtl/scg_gate_bank.sv ***
`timescale 1ns/1ns

module scg_gate_bank
    import scg_pkg::*;
#(
    parameter int NUM_UNITS = `SCG_NUM_UNITS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Requested and applied enables
    input wire logic [NUM_UNITS-1:0] want,
    output logic [NUM_UNITS-1:0] clkEn
);

    generate
        if (NUM_UNITS < 1) begin : gBad
            $error("scg_gate_bank: NUM_UNITS must be at least 1");
        end
        // One enable flop per unit keeps the gate cells glitch free
        for (genvar i = 0; i < NUM_UNITS; i++) begin : gUnit
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    clkEn[i] <= 1'b0;
                end else begin
                    clkEn[i] <= want[i];
                end
            end
        end
    endgenerate

endmodule

// *** rtl/scg_pkg.sv ***
`include "scg_defs.svh"

package scg_pkg;

    typedef logic [`SCG_NUM_UNITS-1:0] scg_units_t;
    typedef logic [`SCG_UNIT_W-1:0] scg_unit_t;

    typedef enum logic [1:0] {
        SCG_RUN,
        SCG_SLEEP,
        SCG_DEEP
    } scg_mode_e;

    // One access from the core toward a gated peripheral
    typedef struct packed {
        logic valid;
        logic write;
        scg_unit_t unit;
    } scg_preq_s;

endpackage

// *** rtl/scg_sleep_gate.sv ***
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module scg_sleep_gate
    import scg_pkg::*;
#(
    parameter int NUM_UNITS = `SCG_NUM_UNITS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [`SCG_ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    // AXI4-Lite read
    input wire logic [`SCG_ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // Power mode and companion enables
    input wire logic sleepActive,
    input wire logic deepSleepActive,
    input wire logic autoGatingSelect,
    input wire logic [31:0] runEnables,
    input wire logic [31:0] deepSleepEnables,
    // Core accesses toward gated units
    input wire scg_preq_s periphReq,
    output logic periphDone,
    output logic periphFault,
    // Unit clock enables
    output scg_units_t unitClkEn
);

    generate
        if (NUM_UNITS != `SCG_NUM_UNITS) begin : gBad
            $error("scg_sleep_gate: unit map is fixed at ten units");
        end
    endgenerate

    function automatic logic hit(
        input logic [`SCG_ADDR_W-1:0] a,
        input logic [`SCG_ADDR_W-1:0] off
    );
        hit = a[`SCG_ADDR_W-1:2] == off[`SCG_ADDR_W-1:2];
    endfunction

    // Unit order: asp0, asp1, ssp0, twi0, tmr0..2, cmp0..2
    function automatic scg_units_t toUnits(input logic [31:0] r);
        toUnits = {r[`SCG_BIT_CMP2], r[`SCG_BIT_CMP1], r[`SCG_BIT_CMP0],
                   r[`SCG_BIT_TMR2], r[`SCG_BIT_TMR1], r[`SCG_BIT_TMR0],
                   r[`SCG_BIT_TWI0], r[`SCG_BIT_SSP0],
                   r[`SCG_BIT_ASP1], r[`SCG_BIT_ASP0]};
    endfunction

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[8*b +: 8] = data[8*b +: 8];
            end
        end
    endfunction

    // Write channel state
    logic awHeld_r;
    logic wHeld_r;
    logic [`SCG_ADDR_W-1:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    // Read channel state
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    // Block state
    logic [31:0] sleepReg_r;
    logic [31:0] sleepReg_nxt;
    logic faultSeen_r;
    scg_unit_t lastFault_r;
    scg_unit_t faultUnit;

    // Write path: both halves are held, then committed together
    wire logic awTake = s_axil_awvalid && s_axil_awready;
    wire logic wTake = s_axil_wvalid && s_axil_wready;
    wire logic wrGo = awHeld_r && wHeld_r && !bvalid_r;
    wire logic wrSleep = wrGo && hit(awAddr_r, `SCG_SLEEP_OFF);
    wire logic wrStatus = wrGo && hit(awAddr_r, `SCG_STATUS_OFF);
    wire logic wrMapped = wrSleep || wrStatus;

    assign s_axil_awready = !awHeld_r && !bvalid_r;
    assign s_axil_wready = !wHeld_r && !bvalid_r;
    assign s_axil_bvalid = bvalid_r;
    assign s_axil_bresp = bresp_r;

    // Only documented enable bits take a write
    assign sleepReg_nxt = wrSleep ?
        (merge(sleepReg_r, wData_r, wStrb_r) & `SCG_RW_MASK) :
        sleepReg_r;

    wire logic faultClr = wrStatus && wStrb_r[`SCG_ST_FAULT/8] &&
                          wData_r[`SCG_ST_FAULT];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= '0;
            wData_r <= '0;
            wStrb_r <= '0;
        end else begin
            if (awTake) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axil_awaddr;
            end else if (wrGo) begin
                awHeld_r <= 1'b0;
            end
            if (wTake) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axil_wdata;
                wStrb_r <= s_axil_wstrb;
            end else if (wrGo) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= `SCG_RESP_OKAY;
        end else if (wrGo) begin
            bvalid_r <= 1'b1;
            bresp_r <= wrMapped ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
        end else if (s_axil_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sleepReg_r <= `SCG_SLEEP_RST;
        end else begin
            sleepReg_r <= sleepReg_nxt;
        end
    end

    // Mode: run enables rule unless auto gating is chosen and a sleep is active
    wire scg_mode_e modeSel = !autoGatingSelect ? SCG_RUN :
                              deepSleepActive ? SCG_DEEP :
                              sleepActive ? SCG_SLEEP : SCG_RUN;

    wire scg_units_t wantUnits =
        (modeSel == SCG_SLEEP) ? toUnits(sleepReg_r) :
        (modeSel == SCG_DEEP) ? toUnits(deepSleepEnables) :
        toUnits(runEnables);

    scg_gate_bank #(
        .NUM_UNITS(NUM_UNITS)
    ) uGates (
        .ref_clk(ref_clk),
        .rst(rst),
        .want(wantUnits),
        .clkEn(unitClkEn)
    );

    scg_access_check #(
        .NUM_UNITS(NUM_UNITS)
    ) uCheck (
        .ref_clk(ref_clk),
        .rst(rst),
        .req(periphReq),
        .clkEn(unitClkEn),
        .done(periphDone),
        .fault(periphFault),
        .faultUnit(faultUnit)
    );

    // Sticky fault record; a new fault beats a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            faultSeen_r <= 1'b0;
            lastFault_r <= '0;
        end else if (periphFault) begin
            faultSeen_r <= 1'b1;
            lastFault_r <= faultUnit;
        end else if (faultClr) begin
            faultSeen_r <= 1'b0;
        end
    end

    wire logic [31:0] statusWord = {4'h0, lastFault_r, 3'h0, faultSeen_r,
                                    1'b0, autoGatingSelect, modeSel,
                                    6'h00, unitClkEn};

    // Read path: one word per request, data from a flop
    wire logic arTake = s_axil_arvalid && s_axil_arready;
    wire logic rdSleep = hit(s_axil_araddr, `SCG_SLEEP_OFF);
    wire logic rdStatus = hit(s_axil_araddr, `SCG_STATUS_OFF);
    wire logic [31:0] rdWord = rdSleep ? sleepReg_r :
                               rdStatus ? statusWord : 32'h0000_0000;

    assign s_axil_arready = !rvalid_r;
    assign s_axil_rvalid = rvalid_r;
    assign s_axil_rdata = rdata_r;
    assign s_axil_rresp = rresp_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `SCG_RESP_OKAY;
        end else if (arTake) begin
            rvalid_r <= 1'b1;
            rdata_r <= rdWord;
            rresp_r <= (rdSleep || rdStatus) ? `SCG_RESP_OKAY :
                                                `SCG_RESP_SLVERR;
        end else if (s_axil_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule

// *** verification/scg_core_model.sv ***
`timescale 1ns/1ns

module scg_core_model
    import scg_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Command from the bench
    input wire logic go,
    input wire logic wr,
    input wire scg_unit_t unitSel,
    // Access toward the gate
    output scg_preq_s periphReq
);
    // Core never checks the gate first, so gated units do see accesses
    always_ff @(posedge ref_clk) begin
        periphReq <= '{valid: go, write: wr, unit: unitSel};
    end
endmodule

// *** verification/scg_sleep_gate_asserts.sv ***
`timescale 1ns/1ns
`include "scg_defs.svh"

module scg_sleep_gate_asserts
    import scg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bus and mode
    input wire logic [`SCG_ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic autoGatingSelect,
    input wire logic deepSleepActive,
    input wire logic [31:0] runEnables,
    input wire logic [31:0] deepSleepEnables,
    // Units
    input wire scg_preq_s periphReq,
    input wire logic periphDone,
    input wire logic periphFault,
    input wire scg_units_t unitClkEn
);
    function automatic scg_units_t gm(input logic [31:0] e);
        return {e[26:24], e[18:16], e[12], e[4], e[1:0]};
    endfunction
    wire logic inR = periphReq.unit < 4'ha;
    wire logic on = inR && unitClkEn[periphReq.unit];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_RST: assert property (
        $fell(rst) |-> unitClkEn == '0) else $error("gates set at reset");
    AST_DONE: assert property (
        periphReq.valid && on |=> periphDone && !periphFault)
        else $error("clocked unit access not done");
    AST_FLT: assert property (
        periphReq.valid && inR && !on |=> periphFault && !periphDone)
        else $error("gated unit access not faulted");
    AST_RANGE: assert property (
        periphReq.valid && !inR |=> periphFault) else $error("bad unit");
    AST_IDLE: assert property (
        !periphReq.valid |=> !periphDone && !periphFault)
        else $error("outcome without access");
    AST_RUN: assert property (
        !autoGatingSelect |=> unitClkEn == gm($past(runEnables)))
        else $error("run enables not applied");
    AST_DEEP: assert property (
        autoGatingSelect && deepSleepActive
        |=> unitClkEn == gm($past(deepSleepEnables))) else $error("deep");
    AST_RESV: assert property (
        s_axil_arvalid && s_axil_arready && s_axil_araddr == `SCG_SLEEP_OFF
        |=> (s_axil_rdata & ~`SCG_RW_MASK) == 32'h0) else $error("resv");
endmodule

bind scg_sleep_gate scg_sleep_gate_asserts scg_sleep_gate_asserts_inst (
    .ref_clk, .rst, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rdata, .autoGatingSelect, .deepSleepActive, .runEnables,
    .deepSleepEnables, .periphReq, .periphDone, .periphFault, .unitClkEn
);

// *** verification/testbench.sv ***
`timescale 1ns/1ns
`include "scg_defs.svh"

module testbench;
    import scg_pkg::*;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, runEn = '0, deepEn = '0;
    logic awv = 0, wv = 0, arv = 0, slp = 0, deep = 0, agc = 0, go = 0, wr = 0;
    scg_unit_t unitSel = '0;
    logic awr, wrd, bv, arr, rv, pd, pf;
    logic [1:0] br, rr;
    logic [31:0] rd;
    scg_preq_s pReq;
    scg_units_t clkEn;
    int errors = 0, num_checks = 0;
    always #5 ref_clk = ~ref_clk;
    scg_core_model scg_core_model_inst (.ref_clk, .go, .wr, .unitSel,
        .periphReq(pReq));
    // Both response readies held high: the bench never stalls answers
    scg_sleep_gate scg_sleep_gate_inst (.ref_clk, .rst,
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awv), .s_axil_awready(awr),
        .s_axil_wdata(wdata), .s_axil_wstrb(4'hf), .s_axil_wvalid(wv),
        .s_axil_wready(wrd), .s_axil_bresp(br), .s_axil_bvalid(bv),
        .s_axil_bready(1'h1), .s_axil_araddr(araddr), .s_axil_arvalid(arv),
        .s_axil_arready(arr), .s_axil_rdata(rd), .s_axil_rresp(rr),
        .s_axil_rvalid(rv), .s_axil_rready(1'h1), .sleepActive(slp),
        .deepSleepActive(deep), .autoGatingSelect(agc), .runEnables(runEn),
        .deepSleepEnables(deepEn), .periphReq(pReq), .periphDone(pd),
        .periphFault(pf), .unitClkEn(clkEn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Readies sampled at the falling edge hold until the next rising edge
    task automatic axw(logic [11:0] a, logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        do begin
            @(negedge ref_clk);
            ta = awv && awr;
            tw = wv && wrd;
            tb = bv;
            r = br;
            @(posedge ref_clk);
            if (ta) awv <= 1'h0;
            if (tw) wv <= 1'h0;
        end while (!tb);
    endtask
    task automatic axr(logic [11:0] a, output logic [31:0] d, logic [1:0] r);
        logic ta, tv;
        araddr <= a;
        arv <= 1'h1;
        do begin
            @(negedge ref_clk);
            ta = arv && arr;
            tv = rv;
            d = rd;
            r = rr;
            @(posedge ref_clk);
            if (ta) arv <= 1'h0;
        end while (!tv);
    endtask
    task automatic ce(input scg_units_t e);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(clkEn, e);
        @(posedge ref_clk);
    endtask
    task automatic acc(input scg_unit_t u, input logic ok);
        unitSel <= u;
        wr <= u[0];
        go <= 1'h1;
        @(posedge ref_clk);
        go <= 1'h0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({pd, pf}, {ok, !ok});
        @(posedge ref_clk);
    endtask
    task automatic doReset;
        rst <= 1'h1;
        repeat (16) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic tReset;
        logic [31:0] d;
        logic [1:0] r;
        axr(12'h114, d, r);
        chk(d, 32'h0);
        chk(clkEn, '0);
    endtask
    task automatic tMap;
        int pos[10] = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 26};
        logic [31:0] d;
        logic [1:0] r;
        agc <= 1'h1;
        slp <= 1'h1;
        for (int i = 0; i < 10; i++) begin
            axw(12'h114, 32'h1 << pos[i], r);
            ce(10'h1 << i);
        end
        axw(12'h114, 32'hffff_ffff, r);
        axr(12'h114, d, r);
        chk(d, 32'h0707_1013);
        ce(10'h3ff);
    endtask
    task automatic tMode;
        runEn <= 32'h1;
        deepEn <= 32'h400_0000;
        agc <= 1'h0;
        ce(10'h1);
        agc <= 1'h1;
        slp <= 1'h0;
        ce(10'h1);
        deep <= 1'h1;
        ce(10'h200);
        deep <= 1'h0;
        slp <= 1'h1;
        ce(10'h3ff);
    endtask
    task automatic tFault;
        logic [31:0] d;
        logic [1:0] r;
        axw(12'h114, 32'h1000, r);
        ce(10'h8);
        acc(4'h3, 1'h1);
        acc(4'h0, 1'h0);
        acc(4'hc, 1'h0);
        axr(12'h118, d, r);
        chk(d & 32'h0f10_0000, 32'h0c10_0000);
        axw(12'h118, 32'h10_0000, r);
        axr(12'h118, d, r);
        chk(d[20], 1'h0);
    endtask
    task automatic tUnmap;
        logic [31:0] d;
        logic [1:0] r;
        axw(12'h200, 32'hffff_ffff, r);
        chk(r, `SCG_RESP_SLVERR);
        axr(12'h200, d, r);
        chk(r, `SCG_RESP_SLVERR);
        axr(12'h114, d, r);
        chk(d, 32'h1000);
    endtask
    task automatic tRst2;
        logic [31:0] d;
        logic [1:0] r;
        doReset();
        axr(12'h114, d, r);
        chk(d, 32'h0);
        ce(10'h0);
    endtask
    task summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        doReset();
        tReset();
        tMap();
        tMode();
        tFault();
        tUnmap();
        tRst2();
        summarize();
    end
    initial begin
        #200000;
        errors++;
        summarize();
    end
endmodule
